// File: logic/smb_defs.svh
// Register map, field positions, reset values and timing constants of the serial bit-rate slice.
`ifndef SMB_DEFS_SVH
`define SMB_DEFS_SVH

// APB address width and byte offsets of the registers.
`define SMB_ADDR_W        12
`define SMB_OFF_STATUS    12'h000
`define SMB_OFF_DIVISOR   12'h004
`define SMB_OFF_MODE      12'h008
`define SMB_OFF_CONTROL   12'h00c

// Status register fields.
`define SMB_ST_RX_MP      1
`define SMB_ST_TX_MP      0

// Mode register fields.
`define SMB_MD_SEL_LO     0
`define SMB_MD_SEL_HI     1
`define SMB_MD_MP_FMT     2
`define SMB_MD_SYNC       7

// Control register fields.
`define SMB_CT_RX_EN      4
`define SMB_CT_TX_EN      5

// Widths and reset values.
`define SMB_DIV_W         8
`define SMB_DIV_RESET     8'hff
`define SMB_PRE_W         6
`define SMB_DATA_ZERO     32'h0000_0000

// Clock-source select codes: the prescaler divides the system clock by 1, 4, 16 or 64.
`define SMB_SEL_DIV1      2'h0
`define SMB_SEL_DIV4      2'h1
`define SMB_SEL_DIV16     2'h2
`define SMB_SEL_DIV64     2'h3
`define SMB_PRE_MASK4     6'h03
`define SMB_PRE_MASK16    6'h0f
`define SMB_PRE_MASK64    6'h3f

`endif

// File: logic/smb_pkg.sv
// Types shared by the bit-rate slice modules.
package smb_pkg;
  `include "smb_defs.svh"

  // Register state of the top module.
  typedef struct packed {
    logic [31:0]            prdata;
    logic                   pready;
    logic                   pslverr;
    logic                   rx_multiproc_flag;
    logic                   tx_multiproc_value;
    logic [`SMB_DIV_W-1:0]  bit_rate_divisor;
    logic                   clk_src_sel_hi;
    logic                   clk_src_sel_lo;
    logic                   mp_format;
    logic                   sync_mode;
    logic                   receive_enable;
    logic                   transmit_enable;
    logic                   tx_mp_bit;
    logic                   bit_tick;
  } smb_top_s;

  // Register state of the baud generator.
  typedef struct packed {
    logic [`SMB_PRE_W-1:0]  pre_cnt;
    logic [`SMB_DIV_W-1:0]  cnt;
    logic                   tick;
  } smb_baud_s;
endpackage : smb_pkg

// File: logic/smb_baud_if.sv
// Carrier between the register block and the baud generator.
`timescale 1ns/1ps
`include "smb_defs.svh"
interface smb_baud_if;
  import smb_pkg::*;
  logic [`SMB_DIV_W-1:0] divisor;
  logic [1:0]            clk_sel;
  logic                  run;
  logic                  tick;

  modport gen (input divisor, input clk_sel, input run, output tick);
  modport ctl (output divisor, output clk_sel, output run, input tick);
endinterface : smb_baud_if

// File: logic/smb_baud.sv
// Baud generator: source prescaler followed by a reloading divisor down-counter.
`timescale 1ns/1ps
`include "smb_defs.svh"
module smb_baud
  import smb_pkg::*;
(
  input  wire logic CLK,
  input  wire logic RESETN,
  smb_baud_if.gen   bif
);

  smb_baud_s st_reg;
  smb_baud_s st_next;

  // True on the system-clock cycles that the selected source clock counts on.
  function automatic logic src_enable(input logic [1:0] sel, input logic [`SMB_PRE_W-1:0] pre);
    case (sel)
      `SMB_SEL_DIV1:  src_enable = 1'b1;
      `SMB_SEL_DIV4:  src_enable = (pre & `SMB_PRE_MASK4) == '0;
      `SMB_SEL_DIV16: src_enable = (pre & `SMB_PRE_MASK16) == '0;
      default:        src_enable = (pre & `SMB_PRE_MASK64) == '0;
    endcase
  endfunction : src_enable

  // Stopped, the counter sits loaded so the first bit time is a full one.
  always_comb begin
    st_next      = st_reg;
    st_next.tick = 1'b0;
    if (!bif.run) begin
      st_next.pre_cnt = '0;
      st_next.cnt     = bif.divisor;
    end else begin
      st_next.pre_cnt = st_reg.pre_cnt + 1'b1;
      if (src_enable(bif.clk_sel, st_reg.pre_cnt)) begin
        if (st_reg.cnt == '0) begin
          st_next.tick = 1'b1;
          st_next.cnt  = bif.divisor;
        end else begin
          st_next.cnt = st_reg.cnt - 1'b1;
        end
      end
    end
  end

  // State register.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      st_reg <= '{pre_cnt: '0, cnt: `SMB_DIV_RESET, tick: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign bif.tick = st_reg.tick;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);

  // A tick always reloads the counter from the divisor.
  a_tick_reload: assert property (st_reg.tick && bif.run |-> st_reg.cnt == $past(bif.divisor))
    else $error("baud counter not reloaded on tick");

  // Ticks appear only while running and with the counter at zero.
  a_tick_cause: assert property (st_next.tick |-> bif.run && st_reg.cnt == '0)
    else $error("baud tick without expiry");
endmodule : smb_baud

// File: logic/smb_top.sv
// Multiprocessor bit status, transmit multiprocessor bit and bit-rate divisor with an APB slave.
//
// Notes on behaviour
// - Async multiprocessor frames copy each received character's multiprocessor bit into status bit 1.
// - The received multiprocessor flag is read-only; software writes leave it unchanged.
// - Clearing receive enable in multiprocessor format keeps the flag's previous value.
// - The received flag resets to 0 and then mirrors the received multiprocessor bit.
// - Async multiprocessor transmission appends the status bit 0 value as multiprocessor bit.
// - The transmit value is ignored in sync mode, non-multiprocessor format, or when idle.
// - The transmit multiprocessor value resets to 0 and selects a sent 0 or 1.
// - Bit rate comes from the 8-bit divisor plus the two-bit clock-source select.
// - Software can read the divisor at any time and write it at any time outside standby, transfers notwithstanding.
// - Chip reset and standby both set the divisor to all ones.
`timescale 1ns/1ps
`include "smb_defs.svh"
module smb_top
  import smb_pkg::*;
(
  input  wire  logic                   CLK,
  input  wire  logic                   RESETN,
  input  wire  logic                   PSEL,
  input  wire  logic                   PENABLE,
  input  wire  logic                   PWRITE,
  input  wire  logic [`SMB_ADDR_W-1:0] PADDR,
  input  wire  logic [31:0]            PWDATA,
  output logic       [31:0]            PRDATA,
  output logic                         PREADY,
  output logic                         PSLVERR,
  input  wire  logic                   STANDBY,
  input  wire  logic                   RX_CHAR_DONE,
  input  wire  logic                   RX_MP_SAMPLE,
  input  wire  logic                   TX_ACTIVE,
  output logic                         TX_MP_BIT,
  output logic                         BIT_TICK,
  output logic                         RX_ENABLE,
  output logic                         TX_ENABLE,
  output logic                         MP_FORMAT,
  output logic                         SYNC_MODE
);

  smb_top_s   st_reg;
  smb_top_s   st_next;
  smb_baud_if bif ();

  // Register map, one aligned word per register; unused bits read zero.
  //   0x000 status: bit 1 received flag (read-only), bit 0 transmit value.
  //   0x004 divisor: bits 7:0, all ones after reset and in standby.
  //   0x008 mode: bits 1:0 source select, bit 2 format, bit 7 sync.
  //   0x00c control: bit 4 receive enable, bit 5 transmit enable.
  // Source select 0 to 3 divides the system clock by 1, 4, 16 or 64.
  // Anything else answers with an error, reads zero and drops writes.

  // Address match against one register offset, used for both read and write decode.
  function automatic logic is_reg(input logic [`SMB_ADDR_W-1:0] addr, input logic [`SMB_ADDR_W-1:0] off);
    is_reg = (addr == off);
  endfunction : is_reg

  // True when the address hits any register of the map.
  function automatic logic is_mapped(input logic [`SMB_ADDR_W-1:0] addr);
    is_mapped = is_reg(addr, `SMB_OFF_STATUS) || is_reg(addr, `SMB_OFF_DIVISOR) ||
                is_reg(addr, `SMB_OFF_MODE) || is_reg(addr, `SMB_OFF_CONTROL);
  endfunction : is_mapped

  // Read data mux; unused bits read as zero.
  function automatic logic [31:0] read_mux(input logic [`SMB_ADDR_W-1:0] addr, input smb_top_s s);
    logic [31:0] d;
    d = `SMB_DATA_ZERO;
    if (is_reg(addr, `SMB_OFF_STATUS)) begin
      d[`SMB_ST_RX_MP] = s.rx_multiproc_flag;
      d[`SMB_ST_TX_MP] = s.tx_multiproc_value;
    end
    if (is_reg(addr, `SMB_OFF_DIVISOR)) begin
      d[`SMB_DIV_W-1:0] = s.bit_rate_divisor;
    end
    if (is_reg(addr, `SMB_OFF_MODE)) begin
      d[`SMB_MD_SEL_LO] = s.clk_src_sel_lo;
      d[`SMB_MD_SEL_HI] = s.clk_src_sel_hi;
      d[`SMB_MD_MP_FMT] = s.mp_format;
      d[`SMB_MD_SYNC]   = s.sync_mode;
    end
    if (is_reg(addr, `SMB_OFF_CONTROL)) begin
      d[`SMB_CT_RX_EN] = s.receive_enable;
      d[`SMB_CT_TX_EN] = s.transmit_enable;
    end
    read_mux = d;
  endfunction : read_mux

  // Line-side strobes come from shifters on this same clock, so they need no synchroniser.
  // A character that arrives while receive is off is dropped, not queued.
  // Decoded bus events and line-side conditions.
  logic setup_phase;
  logic wr_commit;
  logic mp_async;
  logic rx_capture;
  logic tx_mp_live;

  // PREADY is a flop raised by the setup cycle, so every access phase lasts exactly one cycle.
  // A master that stretched setup over two cycles would be answered twice; the bus forbids it.
  assign setup_phase = PSEL && !PENABLE;
  assign wr_commit   = PSEL && PENABLE && st_reg.pready && PWRITE;
  assign mp_async    = st_reg.mp_format && !st_reg.sync_mode;
  // Capture only while receiving, so dropping receive enable freezes the flag.
  assign rx_capture  = RX_CHAR_DONE && mp_async && st_reg.receive_enable;
  assign tx_mp_live  = mp_async && st_reg.transmit_enable && TX_ACTIVE;

  // Next-state logic for the whole register block.
  always_comb begin
    st_next          = st_reg;
    st_next.pready   = 1'b0;
    st_next.pslverr  = 1'b0;
    st_next.bit_tick = bif.tick;

    // Read data and error are prepared in the setup cycle and presented in the access cycle.
    // Decoding at setup keeps the access cycle free of the read mux.
    if (setup_phase) begin
      st_next.pready  = 1'b1;
      st_next.pslverr = !is_mapped(PADDR);
      st_next.prdata  = PWRITE ? `SMB_DATA_ZERO : read_mux(PADDR, st_reg);
    end

    // Writes land at the access edge, when the master sees ready.
    // Register writes; the received flag has no write path at all.
    if (wr_commit) begin
      if (is_reg(PADDR, `SMB_OFF_STATUS)) begin
        st_next.tx_multiproc_value = PWDATA[`SMB_ST_TX_MP];
      end
      if (is_reg(PADDR, `SMB_OFF_DIVISOR)) begin
        st_next.bit_rate_divisor = PWDATA[`SMB_DIV_W-1:0];
      end
      if (is_reg(PADDR, `SMB_OFF_MODE)) begin
        st_next.clk_src_sel_lo = PWDATA[`SMB_MD_SEL_LO];
        st_next.clk_src_sel_hi = PWDATA[`SMB_MD_SEL_HI];
        st_next.mp_format      = PWDATA[`SMB_MD_MP_FMT];
        st_next.sync_mode      = PWDATA[`SMB_MD_SYNC];
      end
      if (is_reg(PADDR, `SMB_OFF_CONTROL)) begin
        st_next.receive_enable  = PWDATA[`SMB_CT_RX_EN];
        st_next.transmit_enable = PWDATA[`SMB_CT_TX_EN];
      end
    end

    // Standby wins over a divisor write in the same cycle; the write is lost.
    if (STANDBY) begin
      st_next.bit_rate_divisor = `SMB_DIV_RESET;
    end

    // The flag has no clear: it changes only when a new character arrives.
    // Received multiprocessor bit lands in the status flag.
    if (rx_capture) begin
      st_next.rx_multiproc_flag = RX_MP_SAMPLE;
    end

    // Outgoing multiprocessor bit; forced low whenever the setting is ignored.
    st_next.tx_mp_bit = tx_mp_live ? st_reg.tx_multiproc_value : 1'b0;
  end

  // Standby is not a reset here: it presets the divisor only, flags and modes survive it.
  // State register; reset values come from the defines.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      st_reg.prdata             <= `SMB_DATA_ZERO;
      st_reg.pready             <= 1'b0;
      st_reg.pslverr            <= 1'b0;
      st_reg.rx_multiproc_flag  <= 1'b0;
      st_reg.tx_multiproc_value <= 1'b0;
      st_reg.bit_rate_divisor   <= `SMB_DIV_RESET;
      st_reg.clk_src_sel_hi     <= 1'b0;
      st_reg.clk_src_sel_lo     <= 1'b0;
      st_reg.mp_format          <= 1'b0;
      st_reg.sync_mode          <= 1'b0;
      st_reg.receive_enable     <= 1'b0;
      st_reg.transmit_enable    <= 1'b0;
      st_reg.tx_mp_bit          <= 1'b0;
      st_reg.bit_tick           <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  // A select change takes effect at once, so it may stretch the bit in flight.
  // Baud generator runs only while a direction is enabled and the chip is awake.
  assign bif.divisor = st_reg.bit_rate_divisor;
  assign bif.clk_sel = {st_reg.clk_src_sel_hi, st_reg.clk_src_sel_lo};
  assign bif.run     = !STANDBY && (st_reg.receive_enable || st_reg.transmit_enable);

  smb_baud u_baud (
    .CLK    (CLK),
    .RESETN (RESETN),
    .bif    (bif)
  );

  // Every output is a flop of the state register.
  assign PRDATA    = st_reg.prdata;
  assign PREADY    = st_reg.pready;
  assign PSLVERR   = st_reg.pslverr;
  assign TX_MP_BIT = st_reg.tx_mp_bit;
  assign BIT_TICK  = st_reg.bit_tick;
  assign RX_ENABLE = st_reg.receive_enable;
  assign TX_ENABLE = st_reg.transmit_enable;
  assign MP_FORMAT = st_reg.mp_format;
  assign SYNC_MODE = st_reg.sync_mode;

  // Checks run on the system clock and rest while reset is held.
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);

  // A valid capture copies the sampled bit into the flag one edge later.
  a_mpb_capture: assert property (rx_capture |=> st_reg.rx_multiproc_flag == $past(RX_MP_SAMPLE))
    else $error("received multiprocessor bit not captured");

  // A write to status never alters the received flag unless a capture coincides.
  a_mpb_readonly: assert property (wr_commit && is_reg(PADDR, `SMB_OFF_STATUS) && !rx_capture
                                   |=> $stable(st_reg.rx_multiproc_flag))
    else $error("received flag changed by a write");

  // With receive disabled on two cycles in a row the flag holds across the edge between them.
  a_mpb_hold: assert property (!st_reg.receive_enable ##1 !st_reg.receive_enable
                               |-> $stable(st_reg.rx_multiproc_flag))
    else $error("received flag moved with receive disabled");

  // The flag only ever changes because of a capture.
  a_mpb_cause: assert property (!$stable(st_reg.rx_multiproc_flag) |-> $past(rx_capture))
    else $error("received flag changed without a capture");

  // While transmitting in async multiprocessor format the line bit follows the setting.
  a_txmp_send: assert property (tx_mp_live |=> TX_MP_BIT == $past(st_reg.tx_multiproc_value))
    else $error("transmit multiprocessor bit mismatch");

  // Outside that condition the setting has no effect on the line bit.
  a_txmp_ignored: assert property (!tx_mp_live |=> !TX_MP_BIT)
    else $error("transmit multiprocessor bit leaked");

  // A status write sets the transmit value, seen on the bus by the next read.
  a_txmp_write: assert property (wr_commit && is_reg(PADDR, `SMB_OFF_STATUS)
                                 |=> st_reg.tx_multiproc_value == $past(PWDATA[`SMB_ST_TX_MP]))
    else $error("transmit multiprocessor value not written");

  // A divisor write outside standby always lands.
  a_div_write: assert property (wr_commit && is_reg(PADDR, `SMB_OFF_DIVISOR) && !STANDBY
                                |=> st_reg.bit_rate_divisor == $past(PWDATA[`SMB_DIV_W-1:0]))
    else $error("divisor write lost");

  // Standby forces the divisor to all ones at the next edge.
  a_div_standby: assert property (STANDBY |=> st_reg.bit_rate_divisor == `SMB_DIV_RESET)
    else $error("divisor not preset in standby");

  // Stopped, the generator's tick pipeline drains in two edges.
  a_tick_stopped: assert property (!bif.run
      |-> ##2 !BIT_TICK)
    else $error("bit tick while stopped");

  // A divisor read returns the register as it stood at setup.
  a_div_read: assert property (setup_phase && !PWRITE && is_reg(PADDR, `SMB_OFF_DIVISOR)
      |=> PRDATA[`SMB_DIV_W-1:0] == $past(st_reg.bit_rate_divisor))
    else $error("divisor read mismatch");

  // Without a write or standby the divisor holds.
  a_div_keep: assert property (!STANDBY && !(wr_commit && is_reg(PADDR, `SMB_OFF_DIVISOR))
      |=> $stable(st_reg.bit_rate_divisor))
    else $error("divisor moved on its own");

  // A status read reports the received flag.
  a_mpb_read: assert property (setup_phase && !PWRITE && is_reg(PADDR, `SMB_OFF_STATUS)
      |=> PRDATA[`SMB_ST_RX_MP] == $past(st_reg.rx_multiproc_flag))
    else $error("received flag read mismatch");

  // No capture, no change, whatever receive enable does.
  a_mpb_keep: assert property (!rx_capture
      |=> $stable(st_reg.rx_multiproc_flag))
    else $error("received flag moved without capture");

  // A status read reports the transmit value.
  a_txmp_read: assert property (setup_phase && !PWRITE && is_reg(PADDR, `SMB_OFF_STATUS)
      |=> PRDATA[`SMB_ST_TX_MP] == $past(st_reg.tx_multiproc_value))
    else $error("transmit value read mismatch");

  // The transmit value moves only on a status write.
  a_txmp_keep: assert property (!(wr_commit && is_reg(PADDR, `SMB_OFF_STATUS))
      |=> $stable(st_reg.tx_multiproc_value))
    else $error("transmit value moved without write");

  // Sync mode sends a zero multiprocessor bit.
  a_txmp_sync: assert property (SYNC_MODE
      |=> !TX_MP_BIT)
    else $error("multiprocessor bit sent in sync mode");

  // Transmit disabled sends a zero multiprocessor bit.
  a_txmp_off: assert property (!TX_ENABLE
      |=> !TX_MP_BIT)
    else $error("multiprocessor bit sent while disabled");

  // An idle shifter gets a zero multiprocessor bit.
  a_txmp_idle: assert property (!TX_ACTIVE
      |=> !TX_MP_BIT)
    else $error("multiprocessor bit sent while idle");

  // A mode write lands in the clock-source select.
  a_sel_write: assert property (wr_commit && is_reg(PADDR, `SMB_OFF_MODE)
      |=> bif.clk_sel == $past({PWDATA[`SMB_MD_SEL_HI], PWDATA[`SMB_MD_SEL_LO]}))
    else $error("clock-source select not written");

  // A mode write lands in the format and sync bits.
  a_mode_write: assert property (wr_commit && is_reg(PADDR, `SMB_OFF_MODE)
      |=> MP_FORMAT == $past(PWDATA[`SMB_MD_MP_FMT]) && SYNC_MODE == $past(PWDATA[`SMB_MD_SYNC]))
    else $error("mode bits not written");

  // A control write lands in both enables.
  a_ctl_write: assert property (wr_commit && is_reg(PADDR, `SMB_OFF_CONTROL)
      |=> RX_ENABLE == $past(PWDATA[`SMB_CT_RX_EN]) && TX_ENABLE == $past(PWDATA[`SMB_CT_TX_EN]))
    else $error("control bits not written");

  // An unmapped write changes no register.
  a_map_drop: assert property (wr_commit && !is_mapped(PADDR) && !STANDBY
      |=> $stable(st_reg.bit_rate_divisor) && $stable(st_reg.tx_multiproc_value) && $stable(RX_ENABLE))
    else $error("unmapped write changed a register");

  // Unmapped addresses, and only they, answer with an error.
  a_apb_error: assert property (setup_phase
      |=> PSLVERR != $past(is_mapped(PADDR)))
    else $error("bus error flag wrong");

  // Write cycles return zero read data.
  a_apb_wrzero: assert property (setup_phase && PWRITE
      |=> PRDATA == `SMB_DATA_ZERO)
    else $error("write returned read data");

  // Read data holds between transfers.
  a_prdata_hold: assert property (!setup_phase
      |=> $stable(PRDATA))
    else $error("read data moved outside a transfer");

  // The error flag never stands without ready.
  a_err_ready: assert property (PSLVERR
      |-> PREADY)
    else $error("error without ready");

  // Ready only answers a setup cycle.
  a_ready_setup: assert property (PREADY
      |-> $past(setup_phase))
    else $error("ready without setup");

  // Every setup cycle is answered in exactly one access cycle.
  a_apb_ready: assert property (setup_phase |=> PREADY ##1 !PREADY)
    else $error("access phase length wrong");
endmodule : smb_top

// File: tb/smb_remote.sv
// Remote serial station model: delivers received characters and runs transmit frames.
`timescale 1ns/1ps
module smb_remote (
  input  wire logic clk,
  output logic      rx_char_done,
  output logic      rx_mp_sample,
  output logic      tx_active,
  input  wire logic tx_mp_bit
);
  // Idle levels at time zero; the sample line is never left showing a stale value.
  initial begin
    rx_char_done = 1'b0;
    rx_mp_sample = 1'b1;
    tx_active    = 1'b0;
  end

  // One received character: the multiprocessor bit is valid only with the done pulse.
  task automatic send_char(input logic mp);
    rx_char_done <= 1'b1;
    rx_mp_sample <= mp;
    @(posedge clk);
    rx_char_done <= 1'b0;
    rx_mp_sample <= ~mp;
    @(posedge clk);
  endtask : send_char

  // One transmit frame of len cycles; the appended bit is sampled near the frame end.
  task automatic transmit(input int len, output logic mp);
    tx_active <= 1'b1;
    repeat (len) @(posedge clk);
    mp = tx_mp_bit;
    tx_active <= 1'b0;
    @(posedge clk);
  endtask : transmit
endmodule : smb_remote

// File: tb/tb_serial_mp_bit_and_baud_reg.sv
// Self-checking bench for the multiprocessor bits and bit-rate divisor slice.
`timescale 1ns/1ps
`include "smb_defs.svh"
module tb_serial_mp_bit_and_baud_reg;
  typedef struct packed {
    logic [11:0] a;
    logic [31:0] wd;
    logic [31:0] rexp;
    logic        err;
  } smb_row_s;

  logic        CLK = 1'b0, RESETN = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0, STANDBY = 1'b0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0, PRDATA;
  logic        PREADY, PSLVERR, RX_CHAR_DONE, RX_MP_SAMPLE, TX_ACTIVE, TX_MP_BIT, BIT_TICK;
  logic        RX_ENABLE, TX_ENABLE, MP_FORMAT, SYNC_MODE;
  int          fail_count = 0, total_checks = 0;
  logic [31:0] d;
  logic        e, mp;
  int          g, n;
  localparam logic [31:0] MPF = 32'h1 << `SMB_MD_MP_FMT;
  localparam logic [31:0] SYN = 32'h1 << `SMB_MD_SYNC;
  localparam logic [31:0] REN = 32'h1 << `SMB_CT_RX_EN;
  localparam logic [31:0] TEN = 32'h1 << `SMB_CT_TX_EN;
  // Ordinary register cases: write, then read back.
  smb_row_s rows [6] = '{
    '{`SMB_OFF_DIVISOR, 32'h0000_005a, 32'h0000_005a, 1'b0},
    '{`SMB_OFF_DIVISOR, 32'h0000_0000, 32'h0000_0000, 1'b0},
    '{`SMB_OFF_DIVISOR, 32'hffff_ff01, 32'h0000_0001, 1'b0},
    '{`SMB_OFF_STATUS,  32'h0000_0003, 32'h0000_0001, 1'b0},
    '{`SMB_OFF_STATUS,  32'h0000_0000, 32'h0000_0000, 1'b0},
    '{12'h010,          32'h0000_00ff, 32'h0000_0000, 1'b1}};

  always #5 CLK = ~CLK;

  smb_top dut_u (.CLK(CLK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .STANDBY(STANDBY), .RX_CHAR_DONE(RX_CHAR_DONE), .RX_MP_SAMPLE(RX_MP_SAMPLE), .TX_ACTIVE(TX_ACTIVE),
    .TX_MP_BIT(TX_MP_BIT), .BIT_TICK(BIT_TICK), .RX_ENABLE(RX_ENABLE), .TX_ENABLE(TX_ENABLE),
    .MP_FORMAT(MP_FORMAT), .SYNC_MODE(SYNC_MODE));

  smb_remote rem_u (.clk(CLK), .rx_char_done(RX_CHAR_DONE), .rx_mp_sample(RX_MP_SAMPLE),
    .tx_active(TX_ACTIVE), .tx_mp_bit(TX_MP_BIT));

  task automatic summarize;
    if (fail_count == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : summarize

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  // APB transfer; the slave's wait is bounded, and an idle cycle separates transfers.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int k;
    PSEL    <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE  <= wr;
    PADDR   <= a;
    PWDATA  <= wd;
    @(posedge CLK);
    PENABLE <= 1'b1;
    k = 0;
    do begin
      @(posedge CLK);
      k++;
    end while (PREADY !== 1'b1 && k < 20);
    if (PREADY !== 1'b1) begin
      fail_count++;
      $display("Error at %0t: no bus answer", $time);
      summarize();
    end
    rd = PRDATA;
    err = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLK);
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] wd);
    logic [31:0] r;
    logic        x;
    apb(1'b1, a, wd, r, x);
  endtask : wr

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        x;
    apb(1'b0, a, 32'h0, r, x);
    cmp(r, exp);
  endtask : rdchk

  // Skips to one tick, then counts cycles up to the next; both waits are bounded.
  task automatic tick_gap(output int gap);
    int k;
    k = 0;
    do begin @(posedge CLK); k++; end while (BIT_TICK !== 1'b1 && k < 2000);
    gap = 0;
    do begin @(posedge CLK); gap++; end while (BIT_TICK !== 1'b1 && gap < 2000);
    if (k >= 2000 || gap >= 2000) begin
      fail_count++;
      $display("Error at %0t: no bit tick", $time);
      summarize();
    end
  endtask : tick_gap

  initial begin
    repeat (2) @(posedge CLK);
    RESETN <= 1'b1;
    @(posedge CLK);
    // Register reset values.
    rdchk(`SMB_OFF_DIVISOR, 32'h0000_00ff);
    rdchk(`SMB_OFF_STATUS, 32'h0000_0000);
    cmp({31'h0, TX_MP_BIT}, 32'h0);
    // Table of ordinary cases, the unmapped address last.
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, rows[i].a, rows[i].wd, d, e);
      cmp({31'h0, e}, {31'h0, rows[i].err});
      apb(1'b0, rows[i].a, 32'h0, d, e);
      cmp(d, rows[i].rexp);
      cmp({31'h0, e}, {31'h0, rows[i].err});
    end
    // Receive: the flag follows each character, then holds once receive is disabled.
    wr(`SMB_OFF_MODE, MPF);
    wr(`SMB_OFF_CONTROL, REN | TEN);
    cmp({28'h0, SYNC_MODE, MP_FORMAT, TX_ENABLE, RX_ENABLE}, 32'h7);
    rem_u.send_char(1'b1);
    rdchk(`SMB_OFF_STATUS, 32'h0000_0002);
    rem_u.send_char(1'b0);
    rdchk(`SMB_OFF_STATUS, 32'h0000_0000);
    rem_u.send_char(1'b1);
    wr(`SMB_OFF_STATUS, 32'h0);
    rdchk(`SMB_OFF_STATUS, 32'h0000_0002);
    wr(`SMB_OFF_CONTROL, TEN);
    rem_u.send_char(1'b0);
    rdchk(`SMB_OFF_STATUS, 32'h0000_0002);
    // Transmit: ignored when idle, then both bit values, then ignored when synchronous or not multiprocessor.
    wr(`SMB_OFF_STATUS, 32'h1);
    cmp({31'h0, TX_MP_BIT}, 32'h0);
    rem_u.transmit(4, mp);
    cmp({31'h0, mp}, 32'h1);
    wr(`SMB_OFF_STATUS, 32'h0);
    rem_u.transmit(4, mp);
    cmp({31'h0, mp}, 32'h0);
    wr(`SMB_OFF_STATUS, 32'h1);
    wr(`SMB_OFF_MODE, MPF | SYN);
    rem_u.transmit(4, mp);
    cmp({31'h0, mp}, 32'h0);
    wr(`SMB_OFF_MODE, 32'h0);
    rem_u.transmit(4, mp);
    cmp({31'h0, mp}, 32'h0);
    // Divisor stays accessible in the middle of a transmit frame.
    fork
      rem_u.transmit(30, mp);
      begin
        wr(`SMB_OFF_DIVISOR, 32'h0000_0003);
        rdchk(`SMB_OFF_DIVISOR, 32'h0000_0003);
      end
    join
    // Bit period for every clock-source code with a divisor of 3.
    for (int s = 0; s < 4; s++) begin
      wr(`SMB_OFF_MODE, s);
      tick_gap(g);
      tick_gap(g);
      cmp(g, 4 * (1 << (2 * s)));
    end
    // Standby forces the divisor to all ones and halts the ticks.
    wr(`SMB_OFF_MODE, 32'h0);
    STANDBY <= 1'b1;
    wr(`SMB_OFF_DIVISOR, 32'h0000_0012);
    n = 0;
    repeat (300) begin
      @(posedge CLK);
      if (BIT_TICK === 1'b1) n++;
    end
    cmp(n, 0);
    STANDBY <= 1'b0;
    rdchk(`SMB_OFF_DIVISOR, 32'h0000_00ff);
    // A second reset in mid-run restores the divisor and the transmit value.
    wr(`SMB_OFF_DIVISOR, 32'h0000_0033);
    wr(`SMB_OFF_STATUS, 32'h1);
    RESETN <= 1'b0;
    repeat (2) @(posedge CLK);
    RESETN <= 1'b1;
    @(posedge CLK);
    rdchk(`SMB_OFF_DIVISOR, 32'h0000_00ff);
    rdchk(`SMB_OFF_STATUS, 32'h0000_0000);
    summarize();
  end
endmodule : tb_serial_mp_bit_and_baud_reg
